// ### hdl/fanout_cfg_pkg.sv
// constants, field layout and state codes for the clock fanout config port
// assumes a standard-mode serial host and a 50 MHz core clock
package fanout_cfg_pkg;
   // serial address bytes, write and read form
   localparam logic [7:0] ADDR_WRITE = 8'hD2;
   localparam logic [7:0] ADDR_READ = 8'hD3;
   // byte count sent ahead of read data
   localparam logic [7:0] READ_COUNT = 8'h07;
   // number of configuration latch bytes
   localparam int CFG_BYTES = 7;
   // power-up value of each latch byte
   localparam logic [7:0] CFG_RESET = 8'hFF;
   // value sent for read indices past the last byte
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   // command code plus byte count ahead of write data
   localparam logic [3:0] HDR_BYTES = 4'h2;
   // bits per transferred unit
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // saturation point of the byte index
   localparam logic [3:0] IDX_MAX = 4'hF;
   // number of buffered clock outputs
   localparam int NUM_OUT = 10;
   // field positions inside the latch bytes
   localparam int LO_BYTE = 0;
   localparam int MID_BYTE = 1;
   localparam int HI_BYTE = 2;
   localparam int OUT9_BIT = 7;
   localparam int OUT8_BIT = 6;
   // reset value of the synchronised pin group (bus idles high)
   localparam logic [2:0] PIN_IDLE = 3'h7;
   // all outputs enabled
   localparam logic [9:0] EN_ALL = 10'h3FF;

   // serial engine states, one-hot
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_ADDR = 6'b000010,
      S_ACK = 6'b000100,
      S_RX = 6'b001000,
      S_TX = 6'b010000,
      S_RACK = 6'b100000
   } ser_state_e;
endpackage

// ### hdl/sync2.sv
// two flip-flop level synchroniser with constant reset value
// assumes each bit is an independent level
`timescale 1ns/100ps
module sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   // first stage, read only by the second
   logic [WIDTH-1:0] meta_reg;

   // both stages register only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ### hdl/clk_gate_bank.sv
// per-output glitch-free clock gates driven by the buffer input clock
// assumes enables already synchronised to buf_clk
`timescale 1ns/100ps
module clk_gate_bank (
   input wire logic buf_clk,
   input wire logic rst_n,
   input wire logic [fanout_cfg_pkg::NUM_OUT-1:0] en,
   output logic [fanout_cfg_pkg::NUM_OUT-1:0] clk_out
);
   // enables captured while the input clock is low
   logic [fanout_cfg_pkg::NUM_OUT-1:0] en_lat_reg;
   logic [fanout_cfg_pkg::NUM_OUT-1:0] en_lat_next;

   // next enable is the synchronised request
   always_comb begin
      en_lat_next = en;
   end

   // falling edge capture so changes land in the low phase
   always_ff @(negedge buf_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_lat_reg <= fanout_cfg_pkg::EN_ALL; // all running at power-up
      end else begin
         en_lat_reg <= en_lat_next;
      end
   end

   // one gate per output: copy of input or held low
   genvar i;
   generate
      for (i = 0; i < fanout_cfg_pkg::NUM_OUT; i++) begin : g_gate
         assign clk_out[i] = buf_clk & en_lat_reg[i];
      end
   endgenerate
endmodule

// ### hdl/clock_fanout_i2c.sv
// top of the clock fanout buffer with its serial configuration port
// assumes a standard-mode host on the serial pins, core_clk as link clock
`timescale 1ns/100ps

// Functional notes
// - write address D2 is acknowledged
// - read address D3 is acknowledged
// - command code and count acked, discarded
// - write data stored ascending, each byte acked
// - data loaded until stop condition
// - read sends count then bytes 0..6
// - read-back returns current latch contents
// - every transferred unit is eight bits
// - power-up: all latches default, outputs run
// - drive pin low tristates every output
// - each output enabled or held low
// - ten non-inverting copies of buffer input
// - byte 0 bits 3..0 enable outputs 3..0
// - byte 1 bits 7..4 enable outputs 7..4
// - byte 2 bits 7,6 enable outputs 9,8
// - one runs, zero holds low, default one
module clock_fanout_i2c (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic buf_clk,
   input wire logic serial_clk_pin,
   input wire logic serial_data_pin_i,
   output logic serial_data_pin_o,
   output logic serial_data_pin_oe,
   input wire logic out_drive_en,
   output logic [fanout_cfg_pkg::NUM_OUT-1:0] clk_out,
   output logic [fanout_cfg_pkg::NUM_OUT-1:0] clk_out_oe
);
   // reset copies per domain
   logic core_rst_n;
   logic buf_rst_n;
   // synchronised pins: serial clock, serial data, drive enable
   logic [2:0] pin_s;
   logic scl_s;
   logic sda_s;
   logic drive_s;
   // previous pin levels for edge detection
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic scl_prev_next;
   logic sda_prev_next;
   // bus events
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   // serial engine state
   fanout_cfg_pkg::ser_state_e state_reg;
   fanout_cfg_pkg::ser_state_e state_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [3:0] byte_idx_reg;
   logic [3:0] byte_idx_next;
   logic rw_reg;
   logic rw_next;
   logic rack_ok_reg;
   logic rack_ok_next;
   logic sda_oe_reg;
   logic sda_oe_next;
   // configuration latches
   logic [fanout_cfg_pkg::CFG_BYTES-1:0][7:0] cfg_reg;
   logic [fanout_cfg_pkg::CFG_BYTES-1:0][7:0] cfg_next;
   // output controls in the core domain
   logic [fanout_cfg_pkg::NUM_OUT-1:0] en_reg;
   logic [fanout_cfg_pkg::NUM_OUT-1:0] en_next;
   logic [fanout_cfg_pkg::NUM_OUT-1:0] drive_reg;
   logic [fanout_cfg_pkg::NUM_OUT-1:0] drive_next;
   // enables after crossing into buf_clk
   logic [fanout_cfg_pkg::NUM_OUT-1:0] en_buf;

   // byte sent at a given read index: count, then latches
   function automatic logic [7:0] tx_byte(
      input logic [3:0] idx,
      input logic [fanout_cfg_pkg::CFG_BYTES-1:0][7:0] cfg
   );
      logic [7:0] b;
      if (idx == 4'h0) begin
         b = fanout_cfg_pkg::READ_COUNT;
      end else if (idx <= 4'(fanout_cfg_pkg::CFG_BYTES)) begin
         b = cfg[3'(idx - 4'h1)]; // live latch value
      end else begin
         b = fanout_cfg_pkg::IDLE_BYTE;
      end
      return b;
   endfunction

   // core reset release through two flops
   sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_core_rst (
      .clk(core_clk),
      .rst_n(rst_n),
      .d(1'b1),
      .q(core_rst_n)
   );

   // output-side reset release on buf_clk
   sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_buf_rst (
      .clk(buf_clk),
      .rst_n(rst_n),
      .d(1'b1),
      .q(buf_rst_n)
   );

   // pins are asynchronous to the core clock
   sync2 #(.WIDTH(3), .RST_VAL(fanout_cfg_pkg::PIN_IDLE)) u_pin_sync (
      .clk(core_clk),
      .rst_n(core_rst_n),
      .d({serial_clk_pin, serial_data_pin_i, out_drive_en}),
      .q(pin_s)
   );

   assign scl_s = pin_s[2];
   assign sda_s = pin_s[1];
   assign drive_s = pin_s[0];

   // bus events from synchronised levels
   assign scl_rise = scl_s & ~scl_prev_reg;
   assign scl_fall = ~scl_s & scl_prev_reg;
   assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   // open-drain data pin only ever pulls low
   assign serial_data_pin_o = 1'b0;
   assign serial_data_pin_oe = sda_oe_reg;

   // serial engine next state
   always_comb begin
      scl_prev_next = scl_s;
      sda_prev_next = sda_s;
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      byte_idx_next = byte_idx_reg;
      rw_next = rw_reg;
      rack_ok_next = rack_ok_reg;
      sda_oe_next = sda_oe_reg;
      cfg_next = cfg_reg;
      if (stop_det) begin
         // stop ends any transfer, loading already done
         state_next = fanout_cfg_pkg::S_IDLE;
         sda_oe_next = 1'b0;
      end else if (start_det) begin
         // start or repeated start: expect an address
         state_next = fanout_cfg_pkg::S_ADDR;
         bit_cnt_next = 4'h0;
         sda_oe_next = 1'b0;
      end else begin
         case (state_reg)
            fanout_cfg_pkg::S_IDLE: begin
               sda_oe_next = 1'b0;
            end
            fanout_cfg_pkg::S_ADDR: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall &&
                            bit_cnt_reg == fanout_cfg_pkg::BYTE_BITS) begin
                  if (shift_reg == fanout_cfg_pkg::ADDR_WRITE ||
                      shift_reg == fanout_cfg_pkg::ADDR_READ) begin
                     sda_oe_next = 1'b1; // address ack
                     rw_next = shift_reg[0];
                     byte_idx_next = 4'h0;
                     state_next = fanout_cfg_pkg::S_ACK;
                  end else begin
                     state_next = fanout_cfg_pkg::S_IDLE;
                  end
               end
            end
            fanout_cfg_pkg::S_ACK: begin
               // ack bit ends at the next falling edge
               if (scl_fall) begin
                  bit_cnt_next = 4'h0;
                  if (rw_reg) begin
                     shift_next = tx_byte(byte_idx_reg, cfg_reg);
                     sda_oe_next = ~shift_next[7];
                     state_next = fanout_cfg_pkg::S_TX;
                  end else begin
                     sda_oe_next = 1'b0;
                     state_next = fanout_cfg_pkg::S_RX;
                  end
               end
            end
            fanout_cfg_pkg::S_RX: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall &&
                            bit_cnt_reg == fanout_cfg_pkg::BYTE_BITS) begin
                  sda_oe_next = 1'b1; // every byte acked
                  // header bytes and overflow are dropped
                  if (byte_idx_reg >= fanout_cfg_pkg::HDR_BYTES &&
                      byte_idx_reg < fanout_cfg_pkg::HDR_BYTES +
                      4'(fanout_cfg_pkg::CFG_BYTES)) begin
                     cfg_next[3'(byte_idx_reg - fanout_cfg_pkg::HDR_BYTES)] =
                        shift_reg; // ascending from byte 0
                  end
                  if (byte_idx_reg != fanout_cfg_pkg::IDX_MAX) begin
                     byte_idx_next = byte_idx_reg + 4'h1;
                  end
                  state_next = fanout_cfg_pkg::S_ACK;
               end
            end
            fanout_cfg_pkg::S_TX: begin
               if (scl_rise) begin
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_reg == fanout_cfg_pkg::BYTE_BITS) begin
                     sda_oe_next = 1'b0; // free the line for host ack
                     rack_ok_next = 1'b0;
                     state_next = fanout_cfg_pkg::S_RACK;
                  end else begin
                     sda_oe_next = ~shift_reg[6];
                     shift_next = {shift_reg[6:0], 1'b1};
                  end
               end
            end
            fanout_cfg_pkg::S_RACK: begin
               if (scl_rise) begin
                  rack_ok_next = ~sda_s;
               end else if (scl_fall) begin
                  if (rack_ok_reg) begin
                     // host acked: send the next byte
                     if (byte_idx_reg != fanout_cfg_pkg::IDX_MAX) begin
                        byte_idx_next = byte_idx_reg + 4'h1;
                     end
                     shift_next = tx_byte(byte_idx_next, cfg_reg);
                     sda_oe_next = ~shift_next[7];
                     bit_cnt_next = 4'h0;
                     state_next = fanout_cfg_pkg::S_TX;
                  end else begin
                     state_next = fanout_cfg_pkg::S_IDLE;
                  end
               end
            end
            default: begin
               state_next = fanout_cfg_pkg::S_IDLE;
               sda_oe_next = 1'b0;
            end
         endcase
      end
   end

   // serial engine registers
   always_ff @(posedge core_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         state_reg <= fanout_cfg_pkg::S_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_idx_reg <= 4'h0;
         rw_reg <= 1'b0;
         rack_ok_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         cfg_reg <= {fanout_cfg_pkg::CFG_BYTES{fanout_cfg_pkg::CFG_RESET}};
      end else begin
         scl_prev_reg <= scl_prev_next;
         sda_prev_reg <= sda_prev_next;
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         byte_idx_reg <= byte_idx_next;
         rw_reg <= rw_next;
         rack_ok_reg <= rack_ok_next;
         sda_oe_reg <= sda_oe_next;
         cfg_reg <= cfg_next; // all ones at power-up
      end
   end

   // latch bits to output enables, and tristate control
   always_comb begin
      en_next = {cfg_reg[fanout_cfg_pkg::HI_BYTE][fanout_cfg_pkg::OUT9_BIT],
                 cfg_reg[fanout_cfg_pkg::HI_BYTE][fanout_cfg_pkg::OUT8_BIT],
                 cfg_reg[fanout_cfg_pkg::MID_BYTE][7:4],
                 cfg_reg[fanout_cfg_pkg::LO_BYTE][3:0]};
      drive_next = {fanout_cfg_pkg::NUM_OUT{drive_s}};
   end

   // output control registers
   always_ff @(posedge core_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         en_reg <= fanout_cfg_pkg::EN_ALL;
         drive_reg <= fanout_cfg_pkg::EN_ALL;
      end else begin
         en_reg <= en_next;
         drive_reg <= drive_next;
      end
   end

   assign clk_out_oe = drive_reg;

   // enables cross to the buffer clock, bit by bit
   sync2 #(.WIDTH(fanout_cfg_pkg::NUM_OUT),
           .RST_VAL(fanout_cfg_pkg::EN_ALL)) u_en_sync (
      .clk(buf_clk),
      .rst_n(buf_rst_n),
      .d(en_reg),
      .q(en_buf)
   );

   // gated copies of the buffer input
   clk_gate_bank u_gates (
      .buf_clk(buf_clk),
      .rst_n(buf_rst_n),
      .en(en_buf),
      .clk_out(clk_out)
   );

   // checks on the core-domain engine
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!core_rst_n);

   a_write_addr_ack: assert property (
      state_reg == fanout_cfg_pkg::S_ADDR && scl_fall &&
      bit_cnt_reg == fanout_cfg_pkg::BYTE_BITS &&
      shift_reg == fanout_cfg_pkg::ADDR_WRITE
      |=> sda_oe_reg && !rw_reg && state_reg == fanout_cfg_pkg::S_ACK)
      else $error("write address not acknowledged");
   a_read_addr_ack: assert property (
      state_reg == fanout_cfg_pkg::S_ADDR && scl_fall &&
      bit_cnt_reg == fanout_cfg_pkg::BYTE_BITS &&
      shift_reg == fanout_cfg_pkg::ADDR_READ
      |=> sda_oe_reg && rw_reg && state_reg == fanout_cfg_pkg::S_ACK)
      else $error("read address not acknowledged");
   a_header_drop: assert property (
      state_reg == fanout_cfg_pkg::S_RX && scl_fall &&
      bit_cnt_reg == fanout_cfg_pkg::BYTE_BITS &&
      byte_idx_reg < fanout_cfg_pkg::HDR_BYTES
      |=> sda_oe_reg && $stable(cfg_reg))
      else $error("header byte altered latches");
   a_data_store: assert property (
      state_reg == fanout_cfg_pkg::S_RX && scl_fall &&
      bit_cnt_reg == fanout_cfg_pkg::BYTE_BITS &&
      byte_idx_reg == fanout_cfg_pkg::HDR_BYTES
      |=> sda_oe_reg && cfg_reg[0] == $past(shift_reg))
      else $error("byte 0 not stored and acked");
   a_stop_release: assert property (
      stop_det |=> state_reg == fanout_cfg_pkg::S_IDLE && !sda_oe_reg)
      else $error("stop did not end transfer");
   a_read_count: assert property (
      state_reg == fanout_cfg_pkg::S_ACK && rw_reg && scl_fall
      |=> shift_reg == fanout_cfg_pkg::READ_COUNT && sda_oe_reg)
      else $error("read count byte wrong");
   a_readback_byte: assert property (
      state_reg == fanout_cfg_pkg::S_RACK && scl_fall && rack_ok_reg &&
      byte_idx_reg == 4'h0 |=> shift_reg == $past(cfg_reg[0]))
      else $error("read-back byte 0 mismatch");
   a_overflow_drop: assert property (
      state_reg == fanout_cfg_pkg::S_RX && scl_fall &&
      bit_cnt_reg == fanout_cfg_pkg::BYTE_BITS && byte_idx_reg > 4'h8
      |=> sda_oe_reg && $stable(cfg_reg))
      else $error("overflow byte altered latches");
   a_low_enables: assert property (
      ##1 en_reg[3:0] == $past(cfg_reg[0][3:0]))
      else $error("outputs 3..0 not following byte 0");
   a_mid_enables: assert property (
      ##1 en_reg[7:4] == $past(cfg_reg[1][7:4]))
      else $error("outputs 7..4 not following byte 1");
   a_high_enables: assert property (
      ##1 en_reg[9:8] == $past(cfg_reg[2][7:6]))
      else $error("outputs 9..8 not following byte 2");
   a_tristate_all: assert property (
      !drive_s ##1 !drive_s |=> clk_out_oe == 10'h000)
      else $error("outputs driven while drive pin low");

   c_write_ack: cover property (state_reg == fanout_cfg_pkg::S_ACK &&
      !rw_reg && byte_idx_reg == 4'h3);
   c_read_data: cover property (state_reg == fanout_cfg_pkg::S_TX &&
      byte_idx_reg == 4'h7);
   c_stop_seen: cover property (stop_det);
   c_out_stopped: cover property (en_reg != fanout_cfg_pkg::EN_ALL);
endmodule

// ### bench/i2c_host_model.sv
// standard-mode serial bus host used as the far-side partner of the block
// assumes a 50 MHz core_clk for its bit timing and a pulled-up data line
`timescale 1ns/100ps
module i2c_host_model (
   input wire logic core_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_rel
);
   // quarter bit period in core cycles, four quarters give 10 us per bit
   localparam int QTR = 125;

   // bus idles released, both lines high
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   // wait one quarter bit, changes land just after a falling core edge
   task automatic wait_q();
      repeat (QTR) @(negedge core_clk);
   endtask

   // one bit: data set while clock low, sampled mid-high
   task automatic bit_xfer(input logic b, output logic s);
      sda_rel = b;
      wait_q();
      scl = 1'b1;
      wait_q();
      s = sda_line;
      wait_q();
      scl = 1'b0;
      wait_q();
   endtask

   // start condition, data falls while clock high
   task automatic start();
      @(negedge core_clk); // line changes stay off the rising edge
      sda_rel = 1'b0;
      wait_q();
      scl = 1'b0;
      wait_q();
   endtask

   // stop condition, data rises while clock high
   task automatic stop();
      sda_rel = 1'b0;
      wait_q();
      scl = 1'b1;
      wait_q();
      sda_rel = 1'b1;
      wait_q();
   endtask

   // whole byte out msb first, ack seen as line low
   task automatic write_byte(input logic [7:0] b, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(b[i], s);
      end
      bit_xfer(1'b1, s);
      acked = (s === 1'b0);
   endtask

   // whole byte in msb first, host always acks
   task automatic read_byte(output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, s);
         b[i] = s;
      end
      bit_xfer(1'b0, s);
   endtask
endmodule

// ### bench/clock_fanout_i2c_output_gating_bench.sv
// self-checking bench for the clock fanout serial configuration port
// assumes the host model drives the bus and the bench resolves the wire
`timescale 1ns/100ps
module clock_fanout_i2c_output_gating_bench;
   logic core_clk = 1'b0; // 50 MHz core clock
   logic buf_clk = 1'b0; // 6 ns buffer input clock
   logic rst_n = 1'b0; // active low reset
   logic out_drive_en = 1'b1; // tristate control
   logic scl; // host serial clock
   logic sda_rel; // host data release
   logic sda_line; // resolved data wire
   logic sda_o; // device data level
   logic sda_oe; // device pulls data
   logic [9:0] clk_out; // gated clock outputs
   logic [9:0] clk_out_oe; // output enables
   int bad_count = 0; // mismatches
   int checked = 0; // comparisons
   logic run_mon = 1'b0; // enables the output monitor

   // pull-up wins unless someone pulls low
   assign sda_line = sda_rel & ~(sda_oe & ~sda_o);

   // clocks, buf_clk offset so edges never meet core edges
   always #10 core_clk = ~core_clk;
   initial begin
      #1.3;
      forever #3 buf_clk = ~buf_clk;
   end

   clock_fanout_i2c clock_fanout_i2c_inst (
      .core_clk(core_clk), .rst_n(rst_n), .buf_clk(buf_clk),
      .serial_clk_pin(scl), .serial_data_pin_i(sda_line),
      .serial_data_pin_o(sda_o), .serial_data_pin_oe(sda_oe),
      .out_drive_en(out_drive_en), .clk_out(clk_out),
      .clk_out_oe(clk_out_oe)
   );

   i2c_host_model i2c_host_model_inst (
      .core_clk(core_clk), .sda_line(sda_line), .scl(scl),
      .sda_rel(sda_rel)
   );

   // one comparison, reported at once
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask

   // sample outputs in buf_clk high and low phases
   task automatic sample_out(output logic [9:0] hi, output logic [9:0] lo);
      @(posedge buf_clk);
      #1 hi = clk_out;
      @(negedge buf_clk);
      #1 lo = clk_out;
   endtask

   // verdict and end of run
   task automatic conclude();
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // enabled output must never be high while buf_clk is low
   always @(posedge core_clk) begin
      if (run_mon && ((clk_out & ~{10{buf_clk}}) !== 10'h000)) begin
         chk("clk_out low phase", 16'h0000, {6'h00, clk_out});
      end
   end

   // power-up state: all outputs driven and running
   task automatic test_defaults();
      logic [9:0] hi, lo;
      repeat (10) @(negedge core_clk);
      chk("oe default", {6'h00, fanout_cfg_pkg::EN_ALL},
          {6'h00, clk_out_oe});
      sample_out(hi, lo);
      chk("out high default", 16'h03FF, {6'h00, hi});
      chk("out low default", 16'h0000, {6'h00, lo});
   endtask

   // block write of header plus eight data bytes, last one past the latches
   task automatic test_write();
      logic a;
      logic [9:0] hi, lo;
      logic [7:0] data [8] = '{8'h05, 8'hA0, 8'h40, 8'h96, 8'h11, 8'h22,
                               8'h33, 8'h77};
      i2c_host_model_inst.start();
      i2c_host_model_inst.write_byte(fanout_cfg_pkg::ADDR_WRITE, a);
      chk("write addr ack", 16'h0001, {15'h0000, a});
      i2c_host_model_inst.write_byte(8'h5A, a);
      chk("cmd ack", 16'h0001, {15'h0000, a});
      i2c_host_model_inst.write_byte(8'h3C, a);
      chk("count ack", 16'h0001, {15'h0000, a});
      foreach (data[k]) begin
         i2c_host_model_inst.write_byte(data[k], a);
         chk("data ack", 16'h0001, {15'h0000, a});
      end
      i2c_host_model_inst.stop();
      repeat (20) @(negedge core_clk);
      sample_out(hi, lo);
      chk("out high gated", 16'h01A5, {6'h00, hi});
      chk("out low gated", 16'h0000, {6'h00, lo});
   endtask

   // read-back of count and all seven latch bytes
   task automatic test_read();
      logic a;
      logic [7:0] b;
      logic [7:0] exp [7] = '{8'h05, 8'hA0, 8'h40, 8'h96, 8'h11, 8'h22,
                              8'h33};
      i2c_host_model_inst.start();
      i2c_host_model_inst.write_byte(fanout_cfg_pkg::ADDR_READ, a);
      chk("read addr ack", 16'h0001, {15'h0000, a});
      i2c_host_model_inst.read_byte(b);
      chk("read count", 16'h0007, {8'h00, b});
      foreach (exp[k]) begin
         i2c_host_model_inst.read_byte(b);
         chk("read byte", {8'h00, exp[k]}, {8'h00, b});
      end
      i2c_host_model_inst.stop();
   endtask

   // foreign address is left unacknowledged
   task automatic test_bad_addr();
      logic a;
      i2c_host_model_inst.start();
      i2c_host_model_inst.write_byte(8'hA4, a);
      chk("foreign addr ack", 16'h0000, {15'h0000, a});
      i2c_host_model_inst.stop();
   endtask

   // tristate control floats all outputs, then restores them
   task automatic test_tristate();
      out_drive_en = 1'b0;
      repeat (10) @(negedge core_clk);
      chk("oe off", 16'h0000, {6'h00, clk_out_oe});
      out_drive_en = 1'b1;
      repeat (10) @(negedge core_clk);
      chk("oe on", 16'h03FF, {6'h00, clk_out_oe});
   endtask

   // main sequence
   initial begin
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      run_mon = 1'b1;
      test_defaults();
      test_bad_addr();
      test_write();
      test_read();
      test_tristate();
      conclude();
   end

   // watchdog sized above the expected bus traffic
   initial begin
      repeat (100000) @(posedge core_clk);
      bad_count++;
      conclude();
   end
endmodule
